// ---- common/emi_regs.vh ----
`ifndef EMI_REGS_VH
`define EMI_REGS_VH

// ------------------------------------------------------------
// bank map
// ------------------------------------------------------------
`define EMI_NUM_BANKS 4
`define EMI_BANK0_BASE 32'h0000_0000
`define EMI_BANK1_BASE 32'h0800_0000
`define EMI_BANK2_BASE 32'h1000_0000
`define EMI_BANK3_BASE 32'h1800_0000
`define EMI_BANK_SEL_LSB 27
`define EMI_BANK_SEL_MSB 28
`define EMI_EXT_TOP_LSB 29
`define EMI_EXT_TOP_MSB 31
`define EMI_ADDR_PINS 18

// ------------------------------------------------------------
// bank memory types (3-bit field per bank)
// ------------------------------------------------------------
`define EMI_TYPE_ASRAM 3'h0
`define EMI_TYPE_SFLASH 3'h1
`define EMI_TYPE_SSRAM 3'h2
`define EMI_TYPE_SDRAM 3'h3
`define EMI_TYPE_EDO 3'h4

// ------------------------------------------------------------
// bank data width (2-bit field per bank) and transfer size
// ------------------------------------------------------------
`define EMI_WIDTH_8 2'h0
`define EMI_WIDTH_16 2'h1
`define EMI_WIDTH_32 2'h2
`define EMI_SIZE_BYTE 2'h0
`define EMI_SIZE_HALF 2'h1
`define EMI_SIZE_WORD 2'h2

// ------------------------------------------------------------
// sequence lengths, in memory clock periods; system clock period in ns
// ------------------------------------------------------------
`define EMI_BURST_BEATS 5'h04
`define EMI_SINGLE_BEATS 5'h01
`define EMI_SETUP_PERIODS 1
`define EMI_ACCESS_PERIODS 1
`define EMI_SYS_CLK_NS 20

`endif

// ---- rtl/external_memory_interface.v ----
`timescale 1ns/1ps
`include "emi_regs.vh"
module external_memory_interface (
  // system clock and reset
  input wire i_clock,
  input wire i_rstn,
  // system bus request
  input wire i_req,
  input wire i_write,
  input wire [31:0] i_addr,
  input wire [1:0] i_size,
  input wire i_burst,
  input wire [4:0] i_beats,
  input wire [31:0] i_wdata,
  // system bus answer
  output wire o_busy,
  output wire o_wdata_take,
  output wire o_rvalid,
  output wire [31:0] o_rdata,
  output wire o_done,
  output wire o_error,
  // bank configuration, four fields packed per port
  input wire [11:0] i_bank_type,
  input wire [7:0] i_bank_width,
  input wire [3:0] i_open_burst,
  input wire [15:0] i_decode_cycles,
  input wire [15:0] i_idle_min,
  input wire [15:0] i_idle_rd,
  input wire [15:0] i_idle_wr,
  input wire [15:0] i_clk_div,
  input wire [3:0] i_clk_out_en,
  input wire [3:0] i_clk_gate_idle,
  // memory pins
  output wire [3:0] o_bank_memory_clock,
  output wire [3:0] o_bank_select_lines_n,
  output wire o_setup_phase_strobe_n,
  output wire o_access_strobe_n,
  output wire o_oe_n,
  output wire o_we_n,
  output wire [3:0] o_lane_strobe_n,
  output wire [17:0] o_addr,
  output wire [31:0] o_data,
  output wire o_data_oe,
  input wire [31:0] i_data,
  input wire i_external_wait_ready
);

  localparam ST_IDLE = 6'b00_0001;
  localparam ST_ALIGN = 6'b00_0010;
  localparam ST_SETUP = 6'b00_0100;
  localparam ST_DECODE = 6'b00_1000;
  localparam ST_ACCESS = 6'b01_0000;
  localparam ST_GAP = 6'b10_0000;

  // ----------------------------------------------------------
  // lane helpers
  // ----------------------------------------------------------
  function [1:0] lane_shift;
    input [1:0] width;
    input [1:0] a;
    begin
      case (width)
        `EMI_WIDTH_8: lane_shift = a;
        `EMI_WIDTH_16: lane_shift = {a[1], 1'b0};
        default: lane_shift = 2'h0;
      endcase
    end
  endfunction

  function [3:0] lane_mask;
    input [1:0] width;
    input [1:0] size;
    input [1:0] a;
    begin
      case (width)
        `EMI_WIDTH_8: lane_mask = 4'h1;
        `EMI_WIDTH_16: lane_mask = (size == `EMI_SIZE_BYTE) ? (a[0] ? 4'h2 : 4'h1) : 4'h3;
        default: begin
          if (size == `EMI_SIZE_BYTE)
            lane_mask = 4'h1 << a;
          else if (size == `EMI_SIZE_HALF)
            lane_mask = a[1] ? 4'hc : 4'h3;
          else
            lane_mask = 4'hf;
        end
      endcase
    end
  endfunction

  reg [5:0] state_r, state_nxt;
  reg [1:0] bank_r, bank_nxt;
  reg write_r, write_nxt;
  reg [1:0] size_r, size_nxt;
  reg [31:0] addr_r, addr_nxt;
  reg [4:0] beats_r, beats_nxt;
  reg [3:0] cnt_r, cnt_nxt;
  reg [31:0] data_r, data_nxt;
  reg rdy_s1_r, rdy_s2_r;
  reg [31:0] din_s1_r, din_s2_r;
  reg done_nxt, err_nxt, take_nxt, rvalid_nxt;
  reg [31:0] rdata_nxt;
  reg done_r, err_r, take_r, rvalid_r, busy_r;
  reg [31:0] rdata_r;
  reg [3:0] cs_n_r, bls_n_r;
  reg setup_n_r, access_n_r, oe_n_r, we_n_r, data_oe_r;
  wire [3:0] fall_tick;
  wire active_nxt;
  wire adv;
  wire [1:0] req_bank;
  wire [2:0] req_type;
  wire [1:0] width_cur;
  wire [1:0] shift_cur;
  wire [3:0] gap_sel;
  wire [3:0] gap_len;

  assign active_nxt = ~state_nxt[0];

  // ----------------------------------------------------------
  // per-bank memory clocks, divided from the system clock
  // ----------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `EMI_NUM_BANKS; g = g + 1) begin : mclk
      reg [3:0] div_cnt_r;
      reg phase_r;
      reg clk_out_r;
      wire wrap = (div_cnt_r >= i_clk_div[g*4 +: 4]);
      // controls change on the falling edge, memories sample on the rising one
      assign fall_tick[g] = wrap & phase_r;
      always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
          div_cnt_r <= 4'h0;
          phase_r <= 1'b0;
          clk_out_r <= 1'b0;
        end else begin
          div_cnt_r <= wrap ? 4'h0 : div_cnt_r + 4'h1;
          phase_r <= phase_r ^ wrap;
          clk_out_r <= (phase_r ^ wrap) & i_clk_out_en[g] & (~i_clk_gate_idle[g] | active_nxt);
        end
      end
      assign o_bank_memory_clock[g] = clk_out_r;
    end
  endgenerate

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rdy_s1_r <= 1'b1;
      rdy_s2_r <= 1'b1;
      din_s1_r <= 32'h0000_0000;
      din_s2_r <= 32'h0000_0000;
    end else begin
      rdy_s1_r <= i_external_wait_ready;
      rdy_s2_r <= rdy_s1_r;
      din_s1_r <= i_data;
      din_s2_r <= din_s1_r;
    end
  end

  // sequence steps once per memory clock period, held while ready is low
  assign adv = fall_tick[bank_r] & rdy_s2_r;
  assign req_bank = i_addr[`EMI_BANK_SEL_MSB:`EMI_BANK_SEL_LSB];
  assign req_type = i_bank_type[req_bank*3 +: 3];
  assign width_cur = i_bank_width[bank_r*2 +: 2];
  assign shift_cur = lane_shift(width_cur, addr_r[1:0]);
  assign gap_sel = write_r ? i_idle_wr[bank_r*4 +: 4] : i_idle_rd[bank_r*4 +: 4];
  assign gap_len = (gap_sel > i_idle_min[bank_r*4 +: 4]) ? gap_sel : i_idle_min[bank_r*4 +: 4];

  // ----------------------------------------------------------
  // access sequence
  // ----------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    bank_nxt = bank_r;
    write_nxt = write_r;
    size_nxt = size_r;
    addr_nxt = addr_r;
    beats_nxt = beats_r;
    cnt_nxt = cnt_r;
    data_nxt = data_r;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    take_nxt = 1'b0;
    rvalid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    case (state_r)
      ST_IDLE: begin
        if (i_req) begin
          if (i_addr[`EMI_EXT_TOP_MSB:`EMI_EXT_TOP_LSB] != 3'h0) begin
            err_nxt = 1'b1;
            done_nxt = 1'b1;
          end else begin
            state_nxt = ST_ALIGN;
            bank_nxt = req_bank;
            write_nxt = i_write;
            size_nxt = i_size;
            addr_nxt = i_addr;
            case (req_type)
              `EMI_TYPE_ASRAM: beats_nxt = `EMI_SINGLE_BEATS;
              `EMI_TYPE_SFLASH: beats_nxt = (i_burst & ~i_write) ? `EMI_BURST_BEATS : `EMI_SINGLE_BEATS;
              `EMI_TYPE_SSRAM: begin
                if (!i_burst)
                  beats_nxt = `EMI_SINGLE_BEATS;
                else if (i_open_burst[req_bank] && i_beats != 5'h00)
                  beats_nxt = i_beats;
                else
                  beats_nxt = `EMI_BURST_BEATS;
              end
              `EMI_TYPE_SDRAM, `EMI_TYPE_EDO: beats_nxt = (i_beats == 5'h00) ? `EMI_SINGLE_BEATS : i_beats;
              default: beats_nxt = `EMI_SINGLE_BEATS;
            endcase
          end
        end
      end
      ST_ALIGN: begin
        if (fall_tick[bank_r])
          state_nxt = ST_SETUP;
      end
      ST_SETUP: begin
        if (adv) begin
          cnt_nxt = i_decode_cycles[bank_r*4 +: 4];
          state_nxt = (i_decode_cycles[bank_r*4 +: 4] == 4'h0) ? ST_ACCESS : ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (adv) begin
          cnt_nxt = cnt_r - 4'h1;
          if (cnt_r == 4'h1)
            state_nxt = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (adv) begin
          if (write_r) begin
            take_nxt = 1'b1;
          end else begin
            data_nxt = din_s2_r;
            rdata_nxt = din_s2_r << {shift_cur, 3'b000};
            rvalid_nxt = 1'b1;
          end
          // step by the bank width
          case (width_cur)
            `EMI_WIDTH_8: addr_nxt = addr_r + 32'h0000_0001;
            `EMI_WIDTH_16: addr_nxt = addr_r + 32'h0000_0002;
            default: addr_nxt = addr_r + 32'h0000_0004;
          endcase
          beats_nxt = beats_r - 5'h01;
          if (beats_r == 5'h01) begin
            done_nxt = 1'b1;
            cnt_nxt = gap_len;
            state_nxt = (gap_len == 4'h0) ? ST_IDLE : ST_GAP;
          end
        end
      end
      ST_GAP: begin
        if (adv) begin
          cnt_nxt = cnt_r - 4'h1;
          if (cnt_r == 4'h1)
            state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // write data is placed on its lanes while a write beat is pending
    if (write_r && (state_r == ST_DECODE || state_r == ST_ACCESS || state_r == ST_SETUP) && !take_nxt)
      data_nxt = i_wdata >> {lane_shift(width_cur, addr_r[1:0]), 3'b000};
  end

  // ----------------------------------------------------------
  // state and registered pin drive
  // ----------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
      bank_r <= 2'h0;
      write_r <= 1'b0;
      size_r <= 2'h0;
      addr_r <= 32'h0000_0000;
      beats_r <= 5'h00;
      cnt_r <= 4'h0;
      data_r <= 32'h0000_0000;
      done_r <= 1'b0;
      err_r <= 1'b0;
      take_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      busy_r <= 1'b0;
      cs_n_r <= 4'hf;
      bls_n_r <= 4'hf;
      setup_n_r <= 1'b1;
      access_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      data_oe_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      bank_r <= bank_nxt;
      write_r <= write_nxt;
      size_r <= size_nxt;
      addr_r <= addr_nxt;
      beats_r <= beats_nxt;
      cnt_r <= cnt_nxt;
      data_r <= data_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      take_r <= take_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      busy_r <= active_nxt;
      if (state_nxt == ST_SETUP || state_nxt == ST_DECODE || state_nxt == ST_ACCESS)
        cs_n_r <= ~(4'h1 << bank_nxt);
      else
        cs_n_r <= 4'hf;
      setup_n_r <= (state_nxt != ST_SETUP);
      access_n_r <= (state_nxt != ST_ACCESS);
      oe_n_r <= ~(~write_nxt & (state_nxt == ST_DECODE || state_nxt == ST_ACCESS));
      we_n_r <= ~(write_nxt & (state_nxt == ST_ACCESS));
      if (state_nxt == ST_ACCESS)
        bls_n_r <= ~lane_mask(i_bank_width[bank_nxt*2 +: 2], size_nxt, addr_nxt[1:0]);
      else
        bls_n_r <= 4'hf;
      // the bus is released only while the memory drives read data
      data_oe_r <= ~(~write_nxt & (state_nxt == ST_DECODE || state_nxt == ST_ACCESS));
    end
  end

  assign o_busy = busy_r;
  assign o_wdata_take = take_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_done = done_r;
  assign o_error = err_r;
  assign o_bank_select_lines_n = cs_n_r;
  assign o_setup_phase_strobe_n = setup_n_r;
  assign o_access_strobe_n = access_n_r;
  assign o_oe_n = oe_n_r;
  assign o_we_n = we_n_r;
  assign o_lane_strobe_n = bls_n_r;
  assign o_addr = addr_r[`EMI_ADDR_PINS-1:0];
  assign o_data = data_r;
  assign o_data_oe = data_oe_r;

endmodule

// ---- sim/external_memory_interface_monitor.sv ----
`timescale 1ns/1ps
module emi_monitor (
  // clock and reset
  input wire i_clock,
  input wire i_rstn,
  // request side
  input wire i_req,
  input wire [31:0] i_addr,
  input wire [15:0] i_clk_div,
  input wire o_busy,
  input wire o_done,
  input wire o_error,
  input wire o_rvalid,
  input wire o_wdata_take,
  // memory pins
  input wire [3:0] o_bank_select_lines_n,
  input wire o_setup_phase_strobe_n,
  input wire o_access_strobe_n,
  input wire o_oe_n,
  input wire o_we_n,
  input wire [31:0] o_data,
  input wire o_data_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire quiet = &o_bank_select_lines_n & o_setup_phase_strobe_n & o_access_strobe_n & o_oe_n & o_we_n;
  wire [1:0] bk = {~o_bank_select_lines_n[3] | ~o_bank_select_lines_n[2],
                   ~o_bank_select_lines_n[3] | ~o_bank_select_lines_n[1]};
  wire [3:0] div = i_clk_div[bk*4 +: 4];
  reg [7:0] su_r;
  // ----------------------------------------
  // length of the setup phase in system cycles
  // ----------------------------------------
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) su_r <= 8'h00;
    else su_r <= o_setup_phase_strobe_n ? 8'h00 : su_r + 8'h01;
  end
  sel_onehot_a: assert property ($onehot0(~o_bank_select_lines_n))
    else $error("two banks selected");
  idle_quiet_a: assert property (!o_busy |-> quiet)
    else $error("control active while idle");
  done_quiet_a: assert property (o_done |-> quiet)
    else $error("control active at completion");
  bus_kept_a: assert property (!o_busy && !$past(o_busy) |-> o_data_oe && $stable(o_data))
    else $error("idle bus not kept");
  bus_release_a: assert property (!o_data_oe |-> !o_oe_n && o_we_n)
    else $error("bus released outside read");
  setup_len_a: assert property ($rose(o_setup_phase_strobe_n) |-> su_r == 2 * (div + 1))
    else $error("setup not one memory period");
  setup_select_a: assert property (!o_setup_phase_strobe_n |-> !(&o_bank_select_lines_n) && o_access_strobe_n)
    else $error("setup without select");
  one_dir_a: assert property (!o_access_strobe_n |-> o_we_n != o_oe_n)
    else $error("access without one strobe");
  write_access_a: assert property (!o_we_n |-> !o_access_strobe_n && o_data_oe)
    else $error("write strobe outside access");
  bad_addr_a: assert property (i_req && !o_busy && (|i_addr[31:29]) |=> o_error && o_done)
    else $error("outside address not refused");
  good_addr_a: assert property (i_req && !o_busy && !(|i_addr[31:29]) |=> o_busy && !o_error)
    else $error("valid request not taken");
  cover property (o_rvalid);
  cover property (o_wdata_take);
  cover property (o_error);
endmodule

bind external_memory_interface emi_monitor u_emi_monitor (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_req(i_req), .i_addr(i_addr), .i_clk_div(i_clk_div),
  .o_busy(o_busy), .o_done(o_done), .o_error(o_error), .o_rvalid(o_rvalid), .o_wdata_take(o_wdata_take),
  .o_bank_select_lines_n(o_bank_select_lines_n), .o_setup_phase_strobe_n(o_setup_phase_strobe_n),
  .o_access_strobe_n(o_access_strobe_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_data(o_data),
  .o_data_oe(o_data_oe)
);

// ---- sim/mem_model.sv ----
`timescale 1ns/1ps
module mem_model (
  // controls from the block
  input wire i_clock,
  input wire [3:0] i_mclk,
  input wire [3:0] i_sel_n,
  input wire i_access_n,
  input wire i_oe_n,
  input wire i_we_n,
  input wire [17:0] i_addr,
  input wire [31:0] i_bus,
  input wire i_slow,
  // answers
  output reg [31:0] o_q,
  output reg [31:0] o_wr_word,
  output reg [7:0] o_wr_cnt,
  output wire o_ready
);
  wire [1:0] bk = {~i_sel_n[3] | ~i_sel_n[2], ~i_sel_n[3] | ~i_sel_n[1]};
  wire act = ~&i_sel_n & ~i_access_n;
  wire [7:0] a = i_addr[7:0];
  reg [3:0] hold_r = 4'h0;
  initial o_q = 32'h0000_0000;
  initial o_wr_cnt = 8'h00;
  // ----------------------------------------
  // controls sampled on the bank's rising clock; released bus flips
  // ----------------------------------------
  always @(posedge i_mclk[bk]) begin
    if (act && !i_we_n) begin
      o_wr_word <= i_bus;
      o_wr_cnt <= o_wr_cnt + 8'h01;
    end
    if (act && !i_oe_n) o_q <= {a ^ 8'h3c, a ^ 8'hc3, a ^ 8'h5a, a};
    else o_q <= ~o_q;
  end
  // slow mode: hold ready low at the start of each access
  always @(posedge i_clock) begin
    if (i_slow && $fell(i_access_n)) hold_r <= 4'hf;
    else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
  end
  assign o_ready = (hold_r == 4'h0);
endmodule

// ---- sim/external_memory_interface_tb.sv ----
`timescale 1ns/1ps
module external_memory_interface_tb;
  reg i_clock = 1'b0;
  reg i_rstn = 1'b0;
  reg i_req = 1'b0;
  reg i_write = 1'b0;
  reg [31:0] i_addr = 32'h0000_0000;
  reg [1:0] i_size = 2'h2;
  reg i_burst = 1'b0;
  reg [4:0] i_beats = 5'h01;
  reg [31:0] i_wdata = 32'h0000_0000;
  reg [7:0] width = 8'ha4;
  reg [15:0] decode = 16'h0001;
  reg [15:0] idle_rd = 16'h0000;
  reg [15:0] idle_wr = 16'h0000;
  reg [15:0] div = 16'h2222;
  reg slow = 1'b0;
  reg [11:0] types = 12'h681;
  reg [3:0] open = 4'h0;
  wire busy, take, rvalid, done, error, setup_n, access_n, oe_n, we_n, data_oe, rdy;
  wire [31:0] rdata, o_data, mq, wr_word;
  wire [3:0] mclk, sel_n, lanes_n;
  wire [17:0] o_addr;
  wire [7:0] wr_cnt;
  wire [31:0] bus = data_oe ? o_data : mq;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int nrv, ntk, acc, pre, tail, t;
  reg [31:0] rd;
  reg er;
  reg [3:0] ln;
  external_memory_interface u_external_memory_interface (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_req(i_req), .i_write(i_write), .i_addr(i_addr),
    .i_size(i_size), .i_burst(i_burst), .i_beats(i_beats), .i_wdata(i_wdata), .o_busy(busy),
    .o_wdata_take(take), .o_rvalid(rvalid), .o_rdata(rdata), .o_done(done), .o_error(error),
    .i_bank_type(types), .i_bank_width(width), .i_open_burst(open), .i_decode_cycles(decode),
    .i_idle_min(16'h0020), .i_idle_rd(idle_rd), .i_idle_wr(idle_wr), .i_clk_div(div),
    .i_clk_out_en(4'hf), .i_clk_gate_idle(4'h0), .o_bank_memory_clock(mclk),
    .o_bank_select_lines_n(sel_n), .o_setup_phase_strobe_n(setup_n), .o_access_strobe_n(access_n),
    .o_oe_n(oe_n), .o_we_n(we_n), .o_lane_strobe_n(lanes_n), .o_addr(o_addr), .o_data(o_data),
    .o_data_oe(data_oe), .i_data(bus), .i_external_wait_ready(rdy)
  );
  mem_model u_mem_model (
    .i_clock(i_clock), .i_mclk(mclk), .i_sel_n(sel_n), .i_access_n(access_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_addr(o_addr), .i_bus(bus), .i_slow(slow), .o_q(mq), .o_wr_word(wr_word),
    .o_wr_cnt(wr_cnt), .o_ready(rdy)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  function automatic [31:0] pat(input [7:0] a);
    pat = {a ^ 8'h3c, a ^ 8'hc3, a ^ 8'h5a, a};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [1:0] sz, input logic b,
                      input logic [4:0] n);
    {nrv, ntk, acc, pre, tail, t} = '0;
    @(negedge i_clock);
    {i_write, i_addr, i_size, i_burst, i_beats} = {w, a, sz, b, n};
    i_req = 1'b1;
    do begin
      @(negedge i_clock);
      i_req = 1'b0;
      t++;
      if (access_n === 1'b0) begin
        acc++;
        ln = lanes_n;
      end else if (acc == 0 && sel_n !== 4'hf) pre++;
      if (rvalid === 1'b1) rd = rdata;
      nrv += (rvalid === 1'b1);
      ntk += (take === 1'b1);
      if (take === 1'b1) i_wdata = i_wdata + 32'h1111_1111;
    end while (done !== 1'b1 && t < 2000);
    er = error;
    while (busy === 1'b1 && t < 2000) begin
      tail++;
      t++;
      @(negedge i_clock);
    end
    chk("completion", t < 2000, 1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset;
    chk("idle pins", {busy, sel_n, setup_n, access_n, oe_n, we_n, data_oe}, 10'h1ff);
    chk("reset bus", o_data, 32'h0000_0000);
  endtask
  task automatic s_word_read;
    div = 16'h3222;
    xfer(0, 32'h1800_0010, 2'h2, 0, 5'h01);
    chk("word data", rd, pat(8'h10));
    chk("setup span", pre, 8);
    chk("access span", acc, 8);
    div = 16'h2222;
  endtask
  task automatic s_narrow;
    xfer(0, 32'h0000_0003, 2'h0, 0, 5'h01);
    chk("byte lane", rd[31:24], 8'h03);
    chk("byte strobes", ln, 4'he);
    chk("decode span", pre, 12);
    xfer(0, 32'h0800_0002, 2'h1, 0, 5'h01);
    chk("half lanes", rd[31:16], 16'h5802);
    chk("half strobes", ln, 4'hc);
    chk("gap busy", tail >= 12, 1);
  endtask
  task automatic s_bursts;
    idle_rd = 16'h0300;
    xfer(0, 32'h1000_0040, 2'h2, 1, 5'h01);
    chk("burst beats", nrv, 4);
    chk("burst access", acc, 24);
    chk("burst last", rd, pat(8'h4c));
    chk("read idle", tail, 18);
    idle_rd = 16'h0000;
    xfer(0, 32'h1800_0020, 2'h2, 1, 5'h03);
    chk("open beats", nrv, 3);
    chk("open last", rd, pat(8'h28));
    xfer(0, 32'h0000_0010, 2'h2, 1, 5'h01);
    chk("flash burst", nrv, 4);
  endtask
  task automatic s_write;
    int c0;
    c0 = wr_cnt;
    i_wdata = 32'h0102_0304;
    idle_wr = 16'h0100;
    xfer(1, 32'h1000_0080, 2'h2, 1, 5'h01);
    chk("write beats", ntk, 4);
    chk("memory writes", wr_cnt - c0, 4);
    chk("last write", wr_word, 32'h3435_3637);
    chk("kept data", o_data, 32'h3435_3637);
    chk("kept drive", data_oe, 1);
    chk("write idle", tail, 6);
    idle_wr = 16'h0000;
  endtask
  task automatic s_stall;
    slow = 1'b1;
    xfer(0, 32'h1800_0004, 2'h2, 0, 5'h01);
    chk("stall data", rd, pat(8'h04));
    chk("stall length", acc > 6, 1);
    slow = 1'b0;
  endtask
  task automatic s_error;
    xfer(0, 32'h2000_0000, 2'h2, 0, 5'h01);
    chk("error flag", er, 1);
    chk("no pins", acc + pre, 0);
  endtask
  task automatic s_modes;
    types = 12'h881;
    open = 4'h4;
    xfer(0, 32'h1800_0030, 2'h2, 1, 5'h02);
    chk("edo beats", nrv, 2);
    chk("edo last", rd, pat(8'h34));
    xfer(0, 32'h1000_0000, 2'h2, 1, 5'h06);
    chk("open sram beats", nrv, 6);
    chk("open sram last", rd, pat(8'h14));
    xfer(0, 32'h0800_0000, 2'h1, 1, 5'h01);
    chk("sram single", nrv, 1);
    xfer(1, 32'h0000_0000, 2'h0, 1, 5'h01);
    chk("flash single write", ntk, 1);
    types = 12'h681;
    open = 4'h0;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict;
    end
  end
  initial begin
    repeat (6) @(negedge i_clock);
    s_reset;
    i_rstn = 1'b1;
    s_word_read;
    s_narrow;
    s_bursts;
    s_write;
    s_stall;
    s_error;
    s_modes;
    give_verdict;
  end
endmodule
